/* File: rtl/aps_cfg.svh */
// Timing and field constants for the amplifier protection sequencer
`ifndef APS_CFG_SVH
`define APS_CFG_SVH

`define APS_CLK_HZ 32'h0098_9680
`define APS_MS_PER_S 32'h0000_03E8
`define APS_TMR_W 8
`define APS_OC_FAULT_INDICATOR_N_MS 8'h32
`define APS_OC_MUTE_MS 8'h64
`define APS_OC_RESUME_MS 8'h96
`define APS_RETRY_MS 8'h64
`define APS_STARTUP_MS 8'h96
`define APS_GAIN_STEP_MS 8'h0A
`define APS_GAIN_W 4
`define APS_GAIN_FULL 4'hF
`define APS_GAIN_ZERO 4'h0
`define APS_GAIN_FLOOR 4'h1

`endif

/* File: rtl/aps_pkg.sv */
// Types shared by the amplifier protection sequencer
package aps_pkg;

	typedef enum logic [1:0]
	{
		APS_MODE_STANDBY = 2'h0,
		APS_MODE_MUTE = 2'h1,
		APS_MODE_OPERATE = 2'h2,
		APS_MODE_SPARE = 2'h3
	} aps_mode_t;

	typedef enum logic [5:0]
	{
		APS_ST_STANDBY = 6'h01,
		APS_ST_WINDOW = 6'h02,
		APS_ST_RUN = 6'h04,
		APS_ST_OC_OFF = 6'h08,
		APS_ST_HOLD_OFF = 6'h10,
		APS_ST_RETRY_WAIT = 6'h20
	} aps_state_t;

endpackage : aps_pkg

/* File: rtl/aps_timer.sv */
// Saturating millisecond counter with synchronous clear
`timescale 1ns/10ps
module aps_timer #(
	parameter int W = 8
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic clear,
	input wire logic tick,
	output logic [W-1:0] count_q
);
	logic [W-1:0] count_d;
	wire at_max = &count_q;

	assign count_d = clear ? '0 : ((tick && !at_max) ? count_q + 1'b1 : count_q);

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			count_q <= '0;
		else
			count_q <= count_d;
	end
endmodule : aps_timer

/* File: rtl/aps_top.sv */
// Protection and restart sequencer for a two-channel switching amplifier
`timescale 1ns/10ps
`include "aps_cfg.svh"
module aps_top #(
	parameter int MS_CYCLES = `APS_CLK_HZ / `APS_MS_PER_S,
	parameter logic [7:0] OC_FAULT_INDICATOR_N_MS = `APS_OC_FAULT_INDICATOR_N_MS,
	parameter logic [7:0] OC_MUTE_MS = `APS_OC_MUTE_MS,
	parameter logic [7:0] OC_RESUME_MS = `APS_OC_RESUME_MS,
	parameter logic [7:0] RETRY_MS = `APS_RETRY_MS,
	parameter logic [7:0] STARTUP_MS = `APS_STARTUP_MS,
	parameter logic [7:0] GAIN_STEP_MS = `APS_GAIN_STEP_MS
) (
	input wire logic clock,
	input wire logic rstn,
	input wire aps_pkg::aps_mode_t mode_sel,
	input wire logic temp_above_145,
	input wire logic temp_at_155,
	input wire logic temp_above_160,
	input wire logic current_limit_active,
	input wire logic limit_timeout,
	input wire logic window_fault,
	input wire logic supply_low_guard,
	input wire logic supply_high_guard,
	input wire logic supply_imbalance_guard,
	output logic power_stage_en,
	output logic mute,
	output logic [`APS_GAIN_W-1:0] gain_level,
	output logic thermal_gain_reduction,
	output logic over_current_guard,
	output logic fault_indicator_n
);
	import aps_pkg::*;

	localparam int NSYNC = 11;
	localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

	// All flags come from analog comparators, so each passes two flops first
	logic [NSYNC-1:0] sync_a_q;
	logic [NSYNC-1:0] sync_b_q;
	wire [NSYNC-1:0] raw_in = {mode_sel, temp_above_145, temp_at_155, temp_above_160, current_limit_active,
		limit_timeout, window_fault, supply_low_guard, supply_high_guard, supply_imbalance_guard};

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			sync_a_q <= '0;
			sync_b_q <= '0;
		end
		else
		begin
			sync_a_q <= raw_in;
			sync_b_q <= sync_a_q;
		end
	end

	wire [1:0] mode_s = sync_b_q[10:9];
	wire t145_s = sync_b_q[8];
	wire t155_s = sync_b_q[7];
	wire t160_s = sync_b_q[6];
	wire cur_s = sync_b_q[5];
	wire tmo_s = sync_b_q[4];
	wire win_s = sync_b_q[3];
	wire low_s = sync_b_q[2];
	wire high_s = sync_b_q[1];
	wire unb_s = sync_b_q[0];

	// Spare code falls back to standby so a broken mode network keeps the stage off
	wire mode_sb = (mode_s == APS_MODE_STANDBY) || (mode_s == APS_MODE_SPARE);
	wire mode_op = (mode_s == APS_MODE_OPERATE);
	wire hard_off = t160_s || high_s;
	wire soft_off = low_s || unb_s;

	logic [15:0] presc_q;
	wire ms_tick = (presc_q == MS_LAST);

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			presc_q <= '0;
		else
			presc_q <= ms_tick ? '0 : presc_q + 16'h0001;
	end

	aps_state_t state_q;
	aps_state_t state_d;
	logic [7:0] st_count;
	logic [7:0] gain_count;
	logic [`APS_GAIN_W-1:0] gain_q;
	logic [`APS_GAIN_W-1:0] gain_d;
	logic op_ready_q;
	logic op_ready_d;

	wire in_run = (state_q == APS_ST_RUN);
	wire in_oc = (state_q == APS_ST_OC_OFF);
	wire in_retry = (state_q == APS_ST_RETRY_WAIT);
	// Supply short found at restart freezes the restart timer at the mute point
	wire oc_block = in_oc && (st_count >= OC_MUTE_MS) && win_s;
	wire st_clear = (state_d != state_q) || (in_retry && soft_off);
	wire st_tick = ms_tick && !oc_block;

	aps_timer #(.W(`APS_TMR_W)) u_st_timer (
		.clock(clock),
		.rstn(rstn),
		.clear(st_clear),
		.tick(st_tick),
		.count_q(st_count)
	);

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			APS_ST_STANDBY: if (!mode_sb) state_d = APS_ST_WINDOW;
			APS_ST_WINDOW: if (!win_s && !hard_off) state_d = APS_ST_RUN;
			APS_ST_RUN: if (tmo_s) state_d = APS_ST_OC_OFF;
			APS_ST_OC_OFF: if (st_count >= OC_RESUME_MS) state_d = APS_ST_RUN;
			APS_ST_HOLD_OFF: if (!hard_off) state_d = APS_ST_RUN;
			// A supply retry is a fresh start-up, so it passes the window check again
			APS_ST_RETRY_WAIT: if (st_count >= RETRY_MS) state_d = APS_ST_WINDOW;
			default: state_d = APS_ST_STANDBY;
		endcase
		if (state_q != APS_ST_STANDBY)
		begin
			if (soft_off)
				state_d = APS_ST_RETRY_WAIT;
			// Window check stage is already off; leaving it would skip the check on restart
			if (hard_off && state_q != APS_ST_WINDOW)
				state_d = APS_ST_HOLD_OFF;
			if (mode_sb)
				state_d = APS_ST_STANDBY;
		end
	end

	// Hold-off restarts keep the ready flag and overcurrent resumes set it; fresh start-ups must sit muted first
	assign op_ready_d = (state_q == APS_ST_STANDBY || state_q == APS_ST_WINDOW || in_retry) ? 1'b0 :
		((in_run && st_count >= STARTUP_MS) || (in_oc && state_d == APS_ST_RUN)) ? 1'b1 : op_ready_q;

	wire gain_step = (gain_count >= GAIN_STEP_MS);

	aps_timer #(.W(`APS_TMR_W)) u_gain_timer (
		.clock(clock),
		.rstn(rstn),
		.clear(gain_step),
		.tick(ms_tick),
		.count_q(gain_count)
	);

	assign gain_d = t155_s ? `APS_GAIN_ZERO :
		(gain_step && t145_s && gain_q > `APS_GAIN_FLOOR) ? gain_q - 4'h1 :
		(gain_step && !t145_s && gain_q < `APS_GAIN_FULL) ? gain_q + 4'h1 : gain_q;

	wire stage_d = in_run || (in_oc && st_count >= OC_MUTE_MS && !win_s);
	// Stage stays enabled while muted, giving idle switching with no audio
	wire mute_d = !(in_run && op_ready_q && mode_op && gain_q != `APS_GAIN_ZERO);
	// A supply short holds the indicator low throughout, so the host sees no toggling
	wire fault_d = !((in_oc && (st_count < OC_FAULT_INDICATOR_N_MS || win_s)) || (state_q == APS_ST_WINDOW && win_s)
		|| (in_run && cur_s));
	wire cap_d = in_run && cur_s;

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			state_q <= APS_ST_STANDBY;
			op_ready_q <= 1'b0;
			gain_q <= `APS_GAIN_FULL;
			power_stage_en <= 1'b0;
			mute <= 1'b1;
			thermal_gain_reduction <= 1'b0;
			over_current_guard <= 1'b0;
			fault_indicator_n <= 1'b1;
		end
		else
		begin
			state_q <= state_d;
			op_ready_q <= op_ready_d;
			gain_q <= gain_d;
			power_stage_en <= stage_d;
			mute <= mute_d;
			thermal_gain_reduction <= t145_s;
			over_current_guard <= cap_d;
			fault_indicator_n <= fault_d;
		end
	end

	assign gain_level = gain_q;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);

	sequence s_hot;
		t155_s ##1 t155_s;
	endsequence

	sequence s_oc_done;
		in_oc && st_count >= OC_RESUME_MS && !mode_sb && !hard_off && !soft_off;
	endsequence

	a_otp_stage_off: assert property (t160_s |-> ##2 !power_stage_en)
		else $error("stage not off after overtemperature");
	a_hot_full_mute: assert property (s_hot |-> ##1 (mute && gain_level == `APS_GAIN_ZERO))
		else $error("not muted at high temperature");
	a_gain_fall_cause: assert property ((gain_q < $past(gain_q) && gain_q != `APS_GAIN_ZERO) |-> $past(t145_s))
		else $error("gain fell without thermal flag");
	a_window_stage_off: assert property ((state_q == APS_ST_WINDOW) |-> ##1 !power_stage_en)
		else $error("stage enabled during window check");
	a_window_halt: assert property ((state_q == APS_ST_WINDOW && win_s && !mode_sb && !hard_off && !soft_off)
		|=> state_q == APS_ST_WINDOW)
		else $error("start-up passed a failed window check");
	a_high_restart: assert property ((state_q == APS_ST_HOLD_OFF && !hard_off && !soft_off && !mode_sb)
		|=> in_run ##1 power_stage_en)
		else $error("no direct restart after supply high");
	a_low_timer_hold: assert property ((in_retry && soft_off) |=> st_count == 8'h00)
		else $error("retry timer ran while supply flag set");
	a_current_cap: assert property ((in_run && cur_s && !tmo_s) |=> over_current_guard && !fault_indicator_n)
		else $error("current cap not shown");
	a_timeout_off: assert property ((in_run && tmo_s && !mode_sb && !hard_off && !soft_off)
		|=> in_oc ##1 !power_stage_en)
		else $error("no shutdown after limit timeout");
	a_oc_fault_indicator_n_low: assert property ((in_oc && st_count < OC_FAULT_INDICATOR_N_MS) |=> !fault_indicator_n)
		else $error("fault indicator not low after shutdown");
	a_oc_resume: assert property (s_oc_done |=> in_run && op_ready_q)
		else $error("no resume at restart time");
	a_supply_block: assert property (oc_block |=> !fault_indicator_n && !power_stage_en)
		else $error("supply short did not block restart");
	a_short_fault_indicator_n_steady: assert property ((in_oc && win_s) |=> !fault_indicator_n)
		else $error("fault indicator released during supply short");
endmodule : aps_top

/* File: tb/aps_host_model.sv */
// Mode-select network and fault readout host for the protection sequencer
`timescale 1ns/10ps
module aps_host_model
	import aps_pkg::*;
(
	input wire logic clock,
	input wire aps_pkg::aps_mode_t mode_req,
	input wire logic fault_indicator_n,
	output aps_pkg::aps_mode_t mode_sel,
	output int fault_falls
);
	logic seen_q;
	// Switch network settles on the falling edge, away from the sampling edge
	initial
	begin
		mode_sel = APS_MODE_STANDBY;
		forever
		begin
			@(negedge clock);
			mode_sel <= mode_req;
		end
	end
	// Host counts falls: a load short toggles, a supply short stays low
	initial
	begin
		fault_falls = 0;
		seen_q = 1'b1;
		forever
		begin
			@(posedge clock);
			seen_q <= fault_indicator_n;
			if (seen_q === 1'b1 && fault_indicator_n === 1'b0)
				fault_falls <= fault_falls + 1;
		end
	end
endmodule : aps_host_model

/* File: tb/amp_protection_sequencer_tb.sv */
// Self-checking bench for the amplifier protection sequencer
`timescale 1ns/10ps
module amp_protection_sequencer_tb;
	import aps_pkg::*;
	// Short ms tick keeps the run small; waits are in these ms except reset and the hot and high restart clock counts
	localparam int MS = 4;
	logic clock, rstn, t145, t155, t160, cla, lto, wf, slo, shi, sim;
	aps_mode_t mode_req, mode_sel;
	logic pse, mute, tgr, ocg, fn;
	logic [3:0] gain;
	int miscompares, cmp_count, falls, f0;
	aps_top #(.MS_CYCLES(MS)) aps_top_i (.clock(clock), .rstn(rstn), .mode_sel(mode_sel),
		.temp_above_145(t145), .temp_at_155(t155), .temp_above_160(t160),
		.current_limit_active(cla), .limit_timeout(lto), .window_fault(wf),
		.supply_low_guard(slo), .supply_high_guard(shi), .supply_imbalance_guard(sim),
		.power_stage_en(pse), .mute(mute), .gain_level(gain), .thermal_gain_reduction(tgr),
		.over_current_guard(ocg), .fault_indicator_n(fn));
	aps_host_model aps_host_model_i (.clock(clock), .mode_req(mode_req),
		.fault_indicator_n(fn), .mode_sel(mode_sel), .fault_falls(falls));
	initial
	begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	task ms(input int n);
		repeat (n * MS) @(negedge clock);
	endtask : ms
	task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task conclude;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : conclude
	task t_startup;
		wf = 1'b1;
		mode_req = APS_MODE_MUTE;
		ms(3);
		chk("window_stage", pse, 0);
		chk("window_fault", fn, 0);
		wf = 1'b0;
		ms(2);
		chk("mute_stage", {pse, mute}, 2'b11);
		mode_req = APS_MODE_OPERATE;
		ms(135);
		chk("early_mute", mute, 1);
		ms(20);
		chk("run_mute", mute, 0);
		$display("test startup done");
	endtask : t_startup
	task t_limits;
		cla = 1'b1;
		ms(1);
		chk("limit_guard", ocg, 1);
		chk("limit_stage", pse, 1);
		chk("limit_fault", fn, 0);
		cla = 1'b0;
		ms(1);
		chk("limit_end", fn, 1);
		t160 = 1'b1;
		ms(1);
		chk("hot_stage", pse, 0);
		t160 = 1'b0;
		repeat (5) @(negedge clock);
		chk("hot_restart", {pse, mute}, 2'b10);
		shi = 1'b1;
		ms(1);
		chk("high_stage", pse, 0);
		shi = 1'b0;
		repeat (5) @(negedge clock);
		chk("high_restart", pse, 1);
		$display("test limits done");
	endtask : t_limits
	task t_load_short;
		f0 = falls;
		lto = 1'b1;
		ms(2);
		chk("short_off", {pse, fn}, 2'b00);
		ms(44);
		chk("fault_indicator_n_low", fn, 0);
		ms(8);
		chk("fault_indicator_n_free", fn, 1);
		ms(50);
		chk("back_mute", {pse, mute}, 2'b11);
		ms(54);
		chk("retry_off", {pse, fn}, 2'b00);
		chk("toggles", falls - f0, 2);
		lto = 1'b0;
		ms(160);
		chk("short_gone", {pse, mute}, 2'b10);
		$display("test load short done");
	endtask : t_load_short
	task t_supply_short;
		f0 = falls;
		lto = 1'b1;
		wf = 1'b1;
		ms(2);
		lto = 1'b0;
		ms(120);
		chk("sup_short", {pse, fn}, 2'b00);
		chk("steady", falls - f0, 1);
		wf = 1'b0;
		ms(3);
		chk("sup_clear", {pse, fn}, 2'b11);
		ms(60);
		$display("test supply short done");
	endtask : t_supply_short
	task t_supply;
		for (int i = 0; i < 2; i++)
		begin
			slo = (i == 0);
			sim = (i == 1);
			ms(1);
			chk("sup_off", pse, 0);
			slo = 1'b0;
			sim = 1'b0;
			ms(94);
			chk("sup_wait", pse, 0);
			ms(10);
			chk("sup_back", {pse, mute}, 2'b11);
			ms(160);
		end
		$display("test supply done");
	endtask : t_supply
	task t_thermal;
		t145 = 1'b1;
		ms(35);
		chk("fold_gain", gain < 4'hF, 1);
		chk("fold_stage", {pse, tgr}, 2'b11);
		t155 = 1'b1;
		ms(1);
		chk("fold_zero", {gain, mute}, 5'h01);
		$display("test thermal done");
	endtask : t_thermal
	// Mode pin passes the network's falling-edge latch too, so allow two ms
	task t_mode_off;
		mode_req = APS_MODE_SPARE;
		ms(2);
		chk("spare_off", {pse, mute}, 2'b01);
		mode_req = APS_MODE_OPERATE;
		ms(3);
		chk("spare_back", pse, 1);
		mode_req = APS_MODE_STANDBY;
		ms(2);
		chk("standby_off", {pse, fn}, 2'b01);
		$display("test mode off done");
	endtask : t_mode_off
	initial
	begin
		{t145, t155, t160, cla, lto, wf, slo, shi, sim} = '0;
		mode_req = APS_MODE_STANDBY;
		miscompares = 0;
		cmp_count = 0;
		rstn = 1'b0;
		repeat (2) @(negedge clock);
		chk("reset_out", {pse, mute, gain}, 6'h1F);
		rstn = 1'b1;
		t_startup();
		t_limits();
		t_load_short();
		t_supply_short();
		t_supply();
		t_thermal();
		t_mode_off();
		conclude();
	end
	// Run needs about 1240 ms of ticks; twice that is a hang
	initial
	begin
		#1_100_000;
		miscompares++;
		conclude();
	end
endmodule : amp_protection_sequencer_tb
